/* design/dum_defines.vh */
// address map, register offsets and reset values of the memory map decoder
`ifndef DUM_DEFINES_VH
`define DUM_DEFINES_VH

`define DUM_AW 11
`define DUM_CHAN_BIT 10
`define DUM_UART_LAST 10'h00f
`define DUM_CFG_FIRST 10'h080
`define DUM_CFG_LAST 10'h09a
`define DUM_DATA_FIRST 10'h100
`define DUM_DATA_LAST 10'h1ff
`define DUM_RXLS_FIRST 10'h200
`define DUM_RXLS_LAST 10'h3ff

`define DUM_OFF_REQ_FLAGS 8'h80
`define DUM_OFF_CODE_ONE 8'h81
`define DUM_OFF_CODE_TWO 8'h82
`define DUM_OFF_CODE_THREE 8'h83
`define DUM_OFF_CNT_CTRL 8'h84
`define DUM_OFF_CNT_LOW 8'h86
`define DUM_OFF_CNT_HIGH 8'h87
`define DUM_OFF_OVS_EIGHT 8'h88
`define DUM_OFF_OVS_FOUR 8'h89
`define DUM_OFF_SOFT_RESET 8'h8a
`define DUM_OFF_SLEEP 8'h8b
`define DUM_OFF_REVISION 8'h8c
`define DUM_OFF_IDENT 8'h8d
`define DUM_OFF_EEPROM 8'h8e
`define DUM_OFF_MASK_LO 8'h8f
`define DUM_OFF_LEVEL_LO 8'h90
`define DUM_OFF_OE_LO 8'h91
`define DUM_OFF_POL_LO 8'h92
`define DUM_OFF_SEL_LO 8'h93
`define DUM_OFF_OD_LO 8'h94
`define DUM_OFF_MASK_HI 8'h95
`define DUM_OFF_LEVEL_HI 8'h96
`define DUM_OFF_OE_HI 8'h97
`define DUM_OFF_POL_HI 8'h98
`define DUM_OFF_SEL_HI 8'h99
`define DUM_OFF_OD_HI 8'h9a

`define DUM_RST_BYTE 8'h00
`define DUM_RST_SEL 8'hff
`define DUM_REV_DEFAULT 8'h01
`define DUM_IDENT_DEFAULT 8'h5a
`define DUM_FIFO_DEPTH 256
`define DUM_FIFO_AW 8
`define DUM_LAST_LANE 2'h3

`endif

/* design/dum_fifo.v */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module dum_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire rst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  localparam [AW:0] FULL = DEPTH[AW:0];
  localparam [AW-1:0] LAST = DEPTH[AW-1:0] - 1'b1;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] count;
  wire doPush;
  wire doPop;

  assign inReady = (count != FULL);
  assign outValid = (count != {(AW+1){1'b0}});
  assign outData = mem[rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      // depth need not be a power of two
      if (doPush) begin
        wrPtr <= (wrPtr == LAST) ? {AW{1'b0}} : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == LAST) ? {AW{1'b0}} : rdPtr + 1'b1;
      end
      if (doPush && !doPop) begin
        count <= count + 1'b1;
      end else if (doPop && !doPush) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // dum_fifo

/* design/dum_map_decoder.v */
// 2K host memory window decoder for the dual serial channel device
`timescale 1ns/10ps
`include "dum_defines.vh"
// How it works
// - all channel and shared registers decode inside one 2K window offset from base.
// - each channel owns a 1024-byte slice, selected by address bit 10.
// - channel control registers sit at 0x000-0x00F and 0x400-0x40F.
// - shared bank appears at 0x080-0x09A in both slices, same storage.
// - mode, reset and sleep bytes accept only the accessing channel's bit.
// - accesses of 1 to 4 bytes; start address picks the byte lanes.
// - data window reads pop receive fifo, writes push transmit fifo.
// - each data window byte advances the fifo pointer by one.
// - second receive window returns each byte paired with its line status flags.
// - four read-only interrupt status bytes at 0x080-0x083 show chanRequest and irqCode.
// - counter control, low and high value bytes are read/write, reset zero.
// - soft reset byte is write-only; bits self-clear after channel reset.
// - revision and identifier bytes are read-only; writes leave them alone.
// - pin interrupt mask bytes at 0x08F and 0x095, reset zero.
// - pin level bytes at 0x090 and 0x096, reset zero.
// - pin output enable bytes at 0x091 and 0x097, reset zero.
// - pin polarity bytes at 0x092 and 0x098, reset zero.
// - pin open drain bytes at 0x094 and 0x09A, reset zero.
// - first status byte shows channel 0 and 1 requests, rest zero.
// - reading a pin level byte clears the pending pin interrupt.
module dum_map_decoder #(
  parameter [7:0] REV_CODE = `DUM_REV_DEFAULT,
  // arbitrary neutral value
  parameter [7:0] IDENT_CODE = `DUM_IDENT_DEFAULT,
  parameter FIFO_DEPTH = `DUM_FIFO_DEPTH,
  parameter FIFO_AW = `DUM_FIFO_AW
) (
  input wire clk,
  input wire rst,
  input wire hostValid,
  output wire hostReady,
  input wire hostWrite,
  input wire [`DUM_AW-1:0] hostAddr,
  input wire [2:0] hostSize,
  input wire [31:0] hostWdata,
  output reg rspValid,
  output reg [31:0] rspRdata,
  output wire uartRegStb,
  output wire uartRegWrite,
  output wire uartRegChan,
  output wire [3:0] uartRegAddr,
  output wire [7:0] uartRegWdata,
  input wire [7:0] uartRegRdata,
  output wire [15:0] txData,
  output wire [1:0] txValid,
  input wire [1:0] txReady,
  input wire [15:0] rxData,
  input wire [15:0] rxStatus,
  input wire [1:0] rxValid,
  output wire [1:0] rxReady,
  input wire [1:0] chanRequest,
  input wire [23:0] irqCode,
  input wire [1:0] softResetDone,
  output reg [7:0] counterControl,
  output reg [15:0] counterValue,
  output reg [7:0] oversampleEight,
  output reg [7:0] oversampleFour,
  output reg [7:0] channelSoftReset,
  output reg [7:0] channelSleep,
  output reg [7:0] eepromControl,
  output reg [15:0] pinIrqMask,
  output reg [15:0] pinLevel,
  output reg [15:0] pinOutputEnable,
  output reg [15:0] pinPolarity,
  output reg [15:0] pinSelect,
  output reg [15:0] pinOpenDrain,
  output reg pinLevelRead,
  output reg counterControlRead,
  output reg requestFlagsRead
);
  localparam S_IDLE = 1'b0;
  localparam S_BUSY = 1'b1;
  localparam RG_NONE = 3'h0;
  localparam RG_UART = 3'h1;
  localparam RG_CFG = 3'h2;
  localparam RG_DATA = 3'h3;
  localparam RG_RXLS = 3'h4;

  reg state;
  reg curWrite;
  reg [`DUM_AW-1:2] curWord;
  reg [1:0] curLane;
  reg [1:0] lastLane;
  reg [31:0] curWdata;
  reg [31:0] rdAcc;

  reg [2:0] region;
  reg [7:0] rdByte;
  reg [7:0] cfgByte;
  reg laneDone;
  reg [1:0] txPush;
  reg [1:0] rxPop;
  reg cfgWrite;
  reg cfgRead;
  reg [31:0] next_rdAcc;
  reg [2:0] sizeClamp;
  reg [2:0] endSum;

  wire [`DUM_AW-1:0] curAddr;
  wire curChan;
  wire [9:0] curOff;
  wire [7:0] cfgOff;
  wire [7:0] laneWdata;
  wire [7:0] chanBit;
  wire [31:0] rxFlat;
  wire [15:0] rxHead;
  wire [1:0] txInReady;
  wire [1:0] rxOutValid;

  assign curAddr = {curWord, curLane};
  assign curChan = curAddr[`DUM_CHAN_BIT];
  assign curOff = curAddr[9:0];
  assign cfgOff = curOff[7:0];
  assign laneWdata = curWdata[{curLane, 3'h0} +: 8];
  assign chanBit = {7'h00, ~curChan} | {6'h00, curChan, 1'b0};
  assign rxHead = rxFlat[{curChan, 4'h0} +: 16];
  assign hostReady = (state == S_IDLE);

  assign uartRegStb = (state == S_BUSY) && (region == RG_UART);
  assign uartRegWrite = curWrite;
  assign uartRegChan = curChan;
  assign uartRegAddr = curOff[3:0];
  assign uartRegWdata = laneWdata;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      dum_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) txFifo (
        .clk(clk),
        .rst(rst),
        .inValid(txPush[g]),
        .inReady(txInReady[g]),
        .inData(laneWdata),
        .outValid(txValid[g]),
        .outReady(txReady[g]),
        .outData(txData[g*8 +: 8])
      );
      dum_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) rxFifo (
        .clk(clk),
        .rst(rst),
        .inValid(rxValid[g]),
        .inReady(rxReady[g]),
        .inData({rxStatus[g*8 +: 8], rxData[g*8 +: 8]}),
        .outValid(rxOutValid[g]),
        .outReady(rxPop[g]),
        .outData(rxFlat[g*16 +: 16])
      );
    end
  endgenerate

  always @* begin
    region = RG_NONE;
    if (curOff <= `DUM_UART_LAST) begin
      region = RG_UART;
    end else if (curOff >= `DUM_CFG_FIRST && curOff <= `DUM_CFG_LAST) begin
      region = RG_CFG;
    end else if (curOff >= `DUM_DATA_FIRST && curOff <= `DUM_DATA_LAST) begin
      region = RG_DATA;
    end else if (curOff >= `DUM_RXLS_FIRST && curOff <= `DUM_RXLS_LAST) begin
      region = RG_RXLS;
    end
  end

  // shared bank read mux
  always @* begin
    case (cfgOff)
      `DUM_OFF_REQ_FLAGS: cfgByte = {6'h00, chanRequest};
      `DUM_OFF_CODE_ONE: cfgByte = irqCode[7:0];
      `DUM_OFF_CODE_TWO: cfgByte = irqCode[15:8];
      `DUM_OFF_CODE_THREE: cfgByte = irqCode[23:16];
      `DUM_OFF_CNT_CTRL: cfgByte = counterControl;
      `DUM_OFF_CNT_LOW: cfgByte = counterValue[7:0];
      `DUM_OFF_CNT_HIGH: cfgByte = counterValue[15:8];
      `DUM_OFF_OVS_EIGHT: cfgByte = oversampleEight;
      `DUM_OFF_OVS_FOUR: cfgByte = oversampleFour;
      `DUM_OFF_SLEEP: cfgByte = channelSleep;
      `DUM_OFF_REVISION: cfgByte = REV_CODE;
      `DUM_OFF_IDENT: cfgByte = IDENT_CODE;
      `DUM_OFF_EEPROM: cfgByte = eepromControl;
      `DUM_OFF_MASK_LO: cfgByte = pinIrqMask[7:0];
      `DUM_OFF_LEVEL_LO: cfgByte = pinLevel[7:0];
      `DUM_OFF_OE_LO: cfgByte = pinOutputEnable[7:0];
      `DUM_OFF_POL_LO: cfgByte = pinPolarity[7:0];
      `DUM_OFF_SEL_LO: cfgByte = pinSelect[7:0];
      `DUM_OFF_OD_LO: cfgByte = pinOpenDrain[7:0];
      `DUM_OFF_MASK_HI: cfgByte = pinIrqMask[15:8];
      `DUM_OFF_LEVEL_HI: cfgByte = pinLevel[15:8];
      `DUM_OFF_OE_HI: cfgByte = pinOutputEnable[15:8];
      `DUM_OFF_POL_HI: cfgByte = pinPolarity[15:8];
      `DUM_OFF_SEL_HI: cfgByte = pinSelect[15:8];
      `DUM_OFF_OD_HI: cfgByte = pinOpenDrain[15:8];
      default: cfgByte = `DUM_RST_BYTE;
    endcase
  end

  // one byte lane per cycle
  always @* begin
    rdByte = `DUM_RST_BYTE;
    laneDone = 1'b1;
    txPush = 2'b00;
    rxPop = 2'b00;
    cfgWrite = 1'b0;
    cfgRead = 1'b0;
    if (state == S_BUSY) begin
      case (region)
        RG_UART: begin
          if (!curWrite) begin
            rdByte = uartRegRdata;
          end
        end
        RG_CFG: begin
          cfgWrite = curWrite;
          cfgRead = !curWrite;
          if (!curWrite) begin
            rdByte = cfgByte;
          end
        end
        RG_DATA: begin
          if (curWrite) begin
            // one byte per lane; full fifo stalls the access
            txPush[curChan] = 1'b1;
            laneDone = txInReady[curChan];
          end else if (rxOutValid[curChan]) begin
            // pop per byte read; empty reads zero
            rdByte = rxHead[7:0];
            rxPop[curChan] = 1'b1;
          end
        end
        RG_RXLS: begin
          // pop on the status lane keeps byte and flags together
          if (!curWrite && rxOutValid[curChan]) begin
            rdByte = curLane[0] ? rxHead[15:8] : rxHead[7:0];
            rxPop[curChan] = curLane[0];
          end
        end
        default: rdByte = `DUM_RST_BYTE;
      endcase
    end
    next_rdAcc = rdAcc;
    next_rdAcc[{curLane, 3'h0} +: 8] = rdByte;
  end

  // last lane, clipped at the word end
  always @* begin
    sizeClamp = hostSize;
    if (hostSize == 3'h0) begin
      sizeClamp = 3'h1;
    end else if (hostSize > 3'h4) begin
      sizeClamp = 3'h4;
    end
    endSum = {1'b0, hostAddr[1:0]} + sizeClamp - 3'h1;
    if (endSum > {1'b0, `DUM_LAST_LANE}) begin
      endSum = {1'b0, `DUM_LAST_LANE};
    end
  end

  // access sequencer
  always @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      curWrite <= 1'b0;
      curWord <= {(`DUM_AW-2){1'b0}};
      curLane <= 2'h0;
      lastLane <= 2'h0;
      curWdata <= 32'h00000000;
      rdAcc <= 32'h00000000;
      rspValid <= 1'b0;
      rspRdata <= 32'h00000000;
    end else begin
      rspValid <= 1'b0;
      case (state)
        S_IDLE: begin
          if (hostValid) begin
            state <= S_BUSY;
            curWrite <= hostWrite;
            curWord <= hostAddr[`DUM_AW-1:2];
            curLane <= hostAddr[1:0];
            lastLane <= endSum[1:0];
            curWdata <= hostWdata;
            rdAcc <= 32'h00000000;
          end
        end
        S_BUSY: begin
          if (laneDone) begin
            rdAcc <= next_rdAcc;
            if (curLane == lastLane) begin
              state <= S_IDLE;
              rspValid <= 1'b1;
              rspRdata <= next_rdAcc;
            end else begin
              curLane <= curLane + 2'h1;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // read side effects, one pulse each
  always @(posedge clk) begin
    if (rst) begin
      pinLevelRead <= 1'b0;
      counterControlRead <= 1'b0;
      requestFlagsRead <= 1'b0;
    end else begin
      pinLevelRead <= cfgRead &&
        (cfgOff == `DUM_OFF_LEVEL_LO || cfgOff == `DUM_OFF_LEVEL_HI);
      counterControlRead <= cfgRead && (cfgOff == `DUM_OFF_CNT_CTRL);
      requestFlagsRead <= cfgRead && (cfgOff == `DUM_OFF_REQ_FLAGS);
    end
  end

  // shared bank storage
  always @(posedge clk) begin
    if (rst) begin
      counterControl <= `DUM_RST_BYTE;
      counterValue <= {`DUM_RST_BYTE, `DUM_RST_BYTE};
      oversampleEight <= `DUM_RST_BYTE;
      oversampleFour <= `DUM_RST_BYTE;
      channelSoftReset <= `DUM_RST_BYTE;
      channelSleep <= `DUM_RST_BYTE;
      eepromControl <= `DUM_RST_BYTE;
      pinIrqMask <= {`DUM_RST_BYTE, `DUM_RST_BYTE};
      pinLevel <= {`DUM_RST_BYTE, `DUM_RST_BYTE};
      pinOutputEnable <= {`DUM_RST_BYTE, `DUM_RST_BYTE};
      pinPolarity <= {`DUM_RST_BYTE, `DUM_RST_BYTE};
      pinSelect <= {`DUM_RST_SEL, `DUM_RST_SEL};
      pinOpenDrain <= {`DUM_RST_BYTE, `DUM_RST_BYTE};
    end else begin
      // self clear; a write in the same cycle wins
      if (cfgWrite && cfgOff == `DUM_OFF_SOFT_RESET) begin
        channelSoftReset <= (channelSoftReset & ~{6'h00, softResetDone})
          | (laneWdata & chanBit);
      end else begin
        channelSoftReset <= channelSoftReset & ~{6'h00, softResetDone};
      end
      if (cfgWrite) begin
        case (cfgOff)
          `DUM_OFF_CNT_CTRL: counterControl <= laneWdata;
          `DUM_OFF_CNT_LOW: counterValue[7:0] <= laneWdata;
          `DUM_OFF_CNT_HIGH: counterValue[15:8] <= laneWdata;
          `DUM_OFF_OVS_EIGHT: begin
            oversampleEight <= (oversampleEight & ~chanBit) | (laneWdata & chanBit);
          end
          `DUM_OFF_OVS_FOUR: begin
            oversampleFour <= (oversampleFour & ~chanBit) | (laneWdata & chanBit);
          end
          `DUM_OFF_SLEEP: begin
            channelSleep <= (channelSleep & ~chanBit) | (laneWdata & chanBit);
          end
          `DUM_OFF_EEPROM: eepromControl <= laneWdata;
          `DUM_OFF_MASK_LO: pinIrqMask[7:0] <= laneWdata;
          `DUM_OFF_LEVEL_LO: pinLevel[7:0] <= laneWdata;
          `DUM_OFF_OE_LO: pinOutputEnable[7:0] <= laneWdata;
          `DUM_OFF_POL_LO: pinPolarity[7:0] <= laneWdata;
          `DUM_OFF_SEL_LO: pinSelect[7:0] <= laneWdata;
          `DUM_OFF_OD_LO: pinOpenDrain[7:0] <= laneWdata;
          `DUM_OFF_MASK_HI: pinIrqMask[15:8] <= laneWdata;
          `DUM_OFF_LEVEL_HI: pinLevel[15:8] <= laneWdata;
          `DUM_OFF_OE_HI: pinOutputEnable[15:8] <= laneWdata;
          `DUM_OFF_POL_HI: pinPolarity[15:8] <= laneWdata;
          `DUM_OFF_SEL_HI: pinSelect[15:8] <= laneWdata;
          `DUM_OFF_OD_HI: pinOpenDrain[15:8] <= laneWdata;
          // read-only and reserved bytes ignore writes
          default: counterControl <= counterControl;
        endcase
      end
    end
  end
endmodule // dum_map_decoder

/* testbench/dum_map_decoder_asserts.sv */
// timing and ownership checks on the memory map decoder ports
`timescale 1ns/10ps
module dum_map_decoder_asserts (
  input wire clk,
  input wire rst,
  input wire hostValid,
  input wire hostReady,
  input wire hostWrite,
  input wire [10:0] hostAddr,
  input wire [2:0] hostSize,
  input wire [31:0] hostWdata,
  input wire rspValid,
  input wire uartRegStb,
  input wire uartRegWrite,
  input wire [7:0] uartRegWdata,
  input wire [15:0] counterValue,
  input wire [7:0] oversampleEight,
  input wire [7:0] channelSleep,
  input wire [15:0] pinSelect,
  input wire pinLevelRead,
  input wire counterControlRead,
  input wire requestFlagsRead
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire take = hostValid && hostReady;
  // only full dwords at offset 0x088 so the next request cannot land inside the window
  wire dwordWr = take && hostWrite && hostSize == 3'h4 && hostAddr[9:0] == 10'h088;

  a_busy_after_take: assert property (take |=> !hostReady)
    else $error("ready stayed high after a take");
  a_one_lane_done: assert property (take && !hostWrite && hostSize == 3'h1 |-> ##2 rspValid)
    else $error("single byte read not answered in two cycles");
  a_done_pulse: assert property (rspValid |-> hostReady && !$past(hostReady))
    else $error("completion outside the end of a busy period");
  a_flags_read: assert property (
    take && !hostWrite && hostAddr[9:0] == 10'h080 |-> ##2 requestFlagsRead)
    else $error("status byte read gave no read pulse");
  a_level_clear: assert property (
    take && !hostWrite && hostAddr[9:0] == 10'h090 |-> ##2 pinLevelRead)
    else $error("pin level read gave no clear pulse");
  a_reset_values: assert property (
    $fell(rst) |-> pinSelect == 16'hffff && counterValue == 16'h0000)
    else $error("bank bytes wrong after reset");
  a_mode_owner: assert property (
    dwordWr && !hostAddr[10] |-> ##5 (oversampleEight & 8'hfe) == ($past(oversampleEight, 5) & 8'hfe))
    else $error("slice 0 changed a foreign mode bit");
  a_sleep_owner: assert property (
    dwordWr && hostAddr[10] |-> ##5 (channelSleep & 8'hfd) == ($past(channelSleep, 5) & 8'hfd))
    else $error("slice 1 changed a foreign sleep bit");
  a_stb_busy: assert property (uartRegStb |-> !hostReady)
    else $error("channel register strobe while idle");
  a_reg_write: assert property (
    take && hostWrite && hostSize == 3'h1 && hostAddr[9:0] == 10'h000 |=>
      uartRegStb && uartRegWrite && uartRegWdata == $past(hostWdata[7:0]))
    else $error("channel register write not passed on");
  a_timer_read: assert property (
    take && !hostWrite && hostAddr[9:0] == 10'h084 |-> ##2 counterControlRead)
    else $error("counter control read gave no pulse");
endmodule // dum_map_decoder_asserts

bind dum_map_decoder dum_map_decoder_asserts i_chk (
  .clk(clk), .rst(rst), .hostValid(hostValid), .hostReady(hostReady), .hostWrite(hostWrite),
  .hostAddr(hostAddr), .hostSize(hostSize), .rspValid(rspValid), .uartRegStb(uartRegStb),
  .counterValue(counterValue), .oversampleEight(oversampleEight), .channelSleep(channelSleep),
  .pinSelect(pinSelect), .pinLevelRead(pinLevelRead), .requestFlagsRead(requestFlagsRead),
  .hostWdata(hostWdata), .uartRegWrite(uartRegWrite), .uartRegWdata(uartRegWdata),
  .counterControlRead(counterControlRead)
);

/* testbench/dum_uart_model.sv */
// behavioural serial channel side: drains transmit, fills receive, answers registers
`timescale 1ns/10ps
module dum_uart_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic drain,
  input wire logic fill,
  output logic [1:0] txReady,
  output logic [15:0] rxData,
  output logic [15:0] rxStatus,
  output logic [1:0] rxValid,
  input wire logic [1:0] rxReady,
  input wire logic uartRegStb,
  input wire logic uartRegChan,
  input wire logic [3:0] uartRegAddr,
  output logic [7:0] uartRegRdata,
  input wire logic [7:0] channelSoftReset,
  output logic [1:0] softResetDone
);
  logic [7:0] k0, k1, cyc;
  assign txReady = {drain, drain};
  assign rxValid = {fill, fill};
  assign rxData = {8'h60 + k1, 8'h40 + k0};
  assign rxStatus = ~rxData;
  // no strobe means no valid byte: show a moving pattern, not the last value
  assign uartRegRdata = uartRegStb ? {3'h5, uartRegChan, uartRegAddr} : cyc;
  always @(posedge clk) begin
    if (rst) begin
      k0 <= 8'h00;
      k1 <= 8'h00;
      cyc <= 8'h00;
      softResetDone <= 2'h0;
    end else begin
      cyc <= cyc + 8'h01;
      if (rxValid[0] && rxReady[0]) k0 <= k0 + 8'h01;
      if (rxValid[1] && rxReady[1]) k1 <= k1 + 8'h01;
      // channel reset finishes one cycle after it is requested
      softResetDone <= channelSoftReset[1:0] & ~softResetDone;
    end
  end
endmodule // dum_uart_model

/* testbench/tb.sv */
// self-checking bench of the memory map decoder
`timescale 1ns/10ps
`include "dum_defines.vh"
`define CHK(a, b) begin \
  checked++; \
  if ((a) !== (b)) begin \
    err_total++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); \
  end \
end
module tb;
  logic clk, rst, hostValid, hostWrite, drain, fill, hold;
  logic [10:0] hostAddr;
  logic [2:0] hostSize;
  logic [31:0] hostWdata, seed, r;
  logic [1:0] chanRequest;
  logic [23:0] irqCode;
  wire hostReady, rspValid, uartRegStb, uartRegChan;
  wire [31:0] rspRdata;
  wire [3:0] uartRegAddr;
  wire [7:0] uartRegRdata, channelSoftReset;
  wire [15:0] txData, rxData, rxStatus;
  wire [1:0] txValid, txReady, rxValid, rxReady, softResetDone;
  logic [32:0] rq[$];
  logic [7:0] tq[2][$];
  logic [32:0] ex;
  logic [7:0] eb;
  int err_total, checked;

  dum_map_decoder #(.FIFO_DEPTH(4), .FIFO_AW(2)) i_dut (
    .clk(clk), .rst(rst), .hostValid(hostValid), .hostReady(hostReady), .hostWrite(hostWrite),
    .hostAddr(hostAddr), .hostSize(hostSize), .hostWdata(hostWdata), .rspValid(rspValid),
    .rspRdata(rspRdata), .uartRegStb(uartRegStb), .uartRegWrite(), .uartRegChan(uartRegChan),
    .uartRegAddr(uartRegAddr), .uartRegWdata(), .uartRegRdata(uartRegRdata), .txData(txData),
    .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxStatus(rxStatus),
    .rxValid(rxValid), .rxReady(rxReady), .chanRequest(chanRequest), .irqCode(irqCode),
    .softResetDone(softResetDone), .counterControl(), .counterValue(), .oversampleEight(),
    .oversampleFour(), .channelSoftReset(channelSoftReset), .channelSleep(), .eepromControl(),
    .pinIrqMask(), .pinLevel(), .pinOutputEnable(), .pinPolarity(), .pinSelect(),
    .pinOpenDrain(), .pinLevelRead(), .counterControlRead(), .requestFlagsRead()
  );

  dum_uart_model i_far (
    .clk(clk), .rst(rst), .drain(drain), .fill(fill), .txReady(txReady), .rxData(rxData),
    .rxStatus(rxStatus), .rxValid(rxValid), .rxReady(rxReady), .uartRegStb(uartRegStb),
    .uartRegChan(uartRegChan), .uartRegAddr(uartRegAddr), .uartRegRdata(uartRegRdata),
    .channelSoftReset(channelSoftReset), .softResetDone(softResetDone)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // request held from just after an edge until the edge that takes it
  task automatic acc(input logic w, input logic [10:0] a, input logic [2:0] s,
                     input logic [31:0] d, input logic [32:0] e);
    @(posedge clk);
    #1;
    hostValid = 1'b1;
    hostWrite = w;
    hostAddr = a;
    hostSize = s;
    hostWdata = d;
    rq.push_back(e);
    while (hostReady !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    hostValid = 1'b0;
  endtask

  task automatic rd(input logic [10:0] a, input logic [2:0] s, input logic [31:0] e);
    acc(1'b0, a, s, 32'h0, {1'b1, e});
  endtask

  task automatic wr(input logic [10:0] a, input logic [2:0] s, input logic [31:0] d);
    acc(1'b1, a, s, d, 33'h0);
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // alternate stalls on the transmit drain once the hold is lifted
  always @(posedge clk) #1 drain = ~hold & ~drain;

  always @(posedge clk) begin
    if (rspValid === 1'b1) begin
      ex = rq.pop_front();
      if (ex[32]) `CHK(rspRdata, ex[31:0])
    end
    for (int i = 0; i < 2; i++)
      if (txValid[i] === 1'b1 && txReady[i] === 1'b1) begin
        eb = tq[i].pop_front();
        `CHK(txData[8*i +: 8], eb)
      end
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    hostValid = 1'b0;
    hostWrite = 1'b0;
    hostAddr = 11'h000;
    hostSize = 3'h1;
    hostWdata = 32'h0;
    hold = 1'b1;
    fill = 1'b1;
    seed = 32'd83;
    chanRequest = 2'h2;
    r = xs();
    irqCode = r[23:0];
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    rd(11'h080, 3'h4, {irqCode, 6'h00, chanRequest});
    rd(11'h090, 3'h4, {`DUM_RST_SEL, 24'h0});
    rd(11'h494, 3'h4, 32'h0);
    rd(11'h098, 3'h4, {16'h0, `DUM_RST_SEL, 8'h00});
    rd(11'h48c, 3'h4, {16'h0, `DUM_IDENT_DEFAULT, `DUM_REV_DEFAULT});
    rd(11'h48d, 3'h3, {16'h0, `DUM_IDENT_DEFAULT, 8'h00});
    r = xs();
    wr(11'h48c, 3'h4, r);
    rd(11'h08c, 3'h4, {r[31:16], `DUM_IDENT_DEFAULT, `DUM_REV_DEFAULT});
    rd(11'h08d, 3'h0, {16'h0, `DUM_IDENT_DEFAULT, 8'h00});
    rd(11'h08e, 3'h7, {r[31:16], 16'h0});
    r = xs();
    wr(11'h484, 3'h4, r);
    rd(11'h084, 3'h4, {r[31:16], 8'h00, r[7:0]});
    r = xs();
    wr(11'h098, 3'h4, r);
    rd(11'h498, 3'h4, {8'h00, r[23:0]});
    r = xs();
    wr(11'h490, 3'h4, r);
    rd(11'h090, 3'h4, r);
    wr(11'h088, 3'h4, 32'hffffffff);
    rd(11'h488, 3'h4, 32'h01000101);
    wr(11'h488, 3'h4, 32'hffffffff);
    rd(11'h08b, 3'h1, 32'h03000000);
    rd(11'h08a, 3'h1, 32'h0);
    `CHK(channelSoftReset, 8'h00)
    wr(11'h010, 3'h4, 32'hffffffff);
    rd(11'h010, 3'h4, 32'h0);
    rd(11'h47c, 3'h4, 32'h0);
    rd(11'h401, 3'h2, 32'h00b2b100);
    r = xs();
    wr(11'h400, 3'h1, r);
    rd(11'h100, 3'h2, 32'h00004140);
    rd(11'h202, 3'h2, 32'hbd420000);
    rd(11'h200, 3'h4, 32'hbb44bc43);
    rd(11'h600, 3'h2, 32'h00009f60);
    for (int k = 0; k < 2; k++) begin
      r = xs();
      for (int b = 0; b < 4; b++) tq[0].push_back(r[8*b +: 8]);
      wr(11'h100 + 11'(4 * k), 3'h4, r);
    end
    repeat (20) @(posedge clk);
    #1 hold = 1'b0;
    r = xs();
    tq[1].push_back(r[15:8]);
    tq[1].push_back(r[23:16]);
    wr(11'h501, 3'h2, r);
    repeat (40) @(posedge clk);
    `CHK(tq[0].size() + tq[1].size() + rq.size(), 0)
    final_report();
  end
endmodule // tb
